// file: core/sfdc_bank.sv
// configuration register bank for the first fractional-n synthesizer, avalon-mm slave
//
// Contract
// R1: doubler enable bit 4 of pump control register drives doubler; resets to one.
// R2: four-bit pump code sets charge pump current; code 8 is 6.4 mA, reset.
// R3: integer divider is twelve bits; zero gives ratio one.
// R4: low divider register supplies bits 7..0, resets 0x66; upper nibble resets zero.
// R5: numerator is 22 bits from three registers, top six bits first; reset zero.
// R6: denominator is 22 bits built likewise from three registers; reset zero.
// R7: dither select bits 3:2: weak, medium, strong, disabled; resets to 3.
// R8: modulator order bits 1:0: integer, first, second, third; resets to zero.
// R9: fractional ratio used only with nonzero order; integer mode ignores fraction.
// R10: undocumented reserved bits read zero; reserved bit 5 stores writes, resets zero.
`timescale 1ns/1ps
`include "sfdc_regs.svh"
module sfdc_bank (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // avalon-mm slave
  input wire logic [8:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic [1:0] AVS_RESPONSE,
  output logic AVS_WAITREQUEST,
  // synthesizer controls
  output logic REF_DOUBLER_ENABLE,
  output logic [3:0] PUMP_CURRENT_SELECT,
  output logic [6:0] PUMP_CURRENT_TENTHS_MA,
  output logic [11:0] INTEGER_FEEDBACK_DIVIDER,
  output logic [21:0] FRACTION_NUMERATOR,
  output logic [21:0] FRACTION_DENOMINATOR,
  output sfdc_pkg::sfdc_dither_type DITHER_SELECT,
  output sfdc_pkg::sfdc_order_type MODULATOR_ORDER,
  output logic [11:0] RATIO_INTEGER,
  output logic [21:0] RATIO_NUMERATOR,
  output logic [21:0] RATIO_DENOMINATOR,
  output logic FRACTION_ACTIVE
);
  import sfdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [7:0] pump_dbl_q, ndiv_hi_q, ndiv_lo_q;
  logic [7:0] num_top_q, num_mid_q, num_low_q;
  logic [7:0] den_top_q, den_mid_q, den_low_q;
  logic [7:0] mod_ctrl_q;
  logic [7:0] rdata_q;
  logic [1:0] resp_q;
  sfdc_state_type state_q, state_d;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // byte address is four times the printed register index
  function automatic logic hit(input logic [8:0] addr, input logic [6:0] idx);
    return (addr[1:0] == 2'h0) && (addr[8:2] == idx);
  endfunction

  wire logic [6:0] idx = AVS_ADDRESS[8:2];
  wire logic aligned = (AVS_ADDRESS[1:0] == 2'h0);
  wire logic in_range = aligned && (idx >= `SFDC_IDX_PUMP_DBL) && (idx <= `SFDC_IDX_MOD_CTRL);
  wire logic req = (AVS_READ || AVS_WRITE) && (state_q == SFDC_ST_IDLE);
  // only lane 0 holds register data; other lanes are ignored
  wire logic wr_go = req && AVS_WRITE && AVS_BYTEENABLE[0];
  wire logic [7:0] wb = AVS_WRITEDATA[7:0];
  wire logic we_pump = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_PUMP_DBL);
  wire logic we_nhi = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_NDIV_HI);
  wire logic we_nlo = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_NDIV_LO);
  wire logic we_ntop = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_NUM_TOP);
  wire logic we_nmid = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_NUM_MID);
  wire logic we_nlow = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_NUM_LOW);
  wire logic we_dtop = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_DEN_TOP);
  wire logic we_dmid = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_DEN_MID);
  wire logic we_dlow = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_DEN_LOW);
  wire logic we_mod = wr_go && hit(AVS_ADDRESS, `SFDC_IDX_MOD_CTRL);

  // read mux; reserved bits other than pump bit 5 are never stored so they read zero
  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    if (hit(AVS_ADDRESS, `SFDC_IDX_PUMP_DBL)) begin
      rsel = pump_dbl_q;
    end else if (hit(AVS_ADDRESS, `SFDC_IDX_NDIV_HI)) begin
      rsel = ndiv_hi_q;
    end else if (hit(AVS_ADDRESS, `SFDC_IDX_NDIV_LO)) begin
      rsel = ndiv_lo_q;
    end else if (hit(AVS_ADDRESS, `SFDC_IDX_NUM_TOP)) begin
      rsel = num_top_q;
    end else if (hit(AVS_ADDRESS, `SFDC_IDX_NUM_MID)) begin
      rsel = num_mid_q;
    end else if (hit(AVS_ADDRESS, `SFDC_IDX_NUM_LOW)) begin
      rsel = num_low_q;
    end else if (hit(AVS_ADDRESS, `SFDC_IDX_DEN_TOP)) begin
      rsel = den_top_q;
    end else if (hit(AVS_ADDRESS, `SFDC_IDX_DEN_MID)) begin
      rsel = den_mid_q;
    end else if (hit(AVS_ADDRESS, `SFDC_IDX_DEN_LOW)) begin
      rsel = den_low_q;
    end else if (hit(AVS_ADDRESS, `SFDC_IDX_MOD_CTRL)) begin
      rsel = mod_ctrl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second edge

  always_comb begin
    state_d = state_q;
    case (state_q)
      SFDC_ST_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          state_d = SFDC_ST_ANSWER;
        end
      end
      SFDC_ST_ANSWER: begin
        state_d = SFDC_ST_IDLE;
      end
      default: begin
        state_d = SFDC_ST_IDLE;
      end
    endcase
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && (state_q != SFDC_ST_ANSWER);
  assign AVS_READDATA = {24'h000000, rdata_q};
  assign AVS_RESPONSE = resp_q;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_q <= SFDC_ST_IDLE;
      rdata_q <= 8'h00;
      resp_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (req) begin
        rdata_q <= AVS_READ ? rsel : 8'h00;
        // unmapped or misaligned addresses answer slave error
        resp_q <= in_range ? 2'h0 : 2'h2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pump_dbl_q <= {2'h0, 1'b0, `SFDC_DBL_RST, `SFDC_CP_RST}; // [R1] [R2] [R10]
      ndiv_hi_q <= {4'h0, `SFDC_NDIV_HI_RST}; // [R4]
      ndiv_lo_q <= `SFDC_NDIV_LO_RST; // [R4]
      num_top_q <= 8'h00; // [R5]
      num_mid_q <= 8'h00;
      num_low_q <= 8'h00;
      den_top_q <= 8'h00; // [R6]
      den_mid_q <= 8'h00;
      den_low_q <= 8'h00;
      mod_ctrl_q <= {4'h0, `SFDC_DITHER_RST, `SFDC_ORDER_RST}; // [R7] [R8]
    end else begin
      if (we_pump) begin
        pump_dbl_q <= wb & `SFDC_MASK_PUMP; // [R10]
      end
      if (we_nhi) begin
        ndiv_hi_q <= wb & `SFDC_MASK_NIB; // [R3]
      end
      if (we_nlo) begin
        ndiv_lo_q <= wb; // [R4]
      end
      if (we_ntop) begin
        num_top_q <= wb & `SFDC_MASK_TOP6; // [R5]
      end
      if (we_nmid) begin
        num_mid_q <= wb;
      end
      if (we_nlow) begin
        num_low_q <= wb;
      end
      if (we_dtop) begin
        den_top_q <= wb & `SFDC_MASK_TOP6; // [R6]
      end
      if (we_dmid) begin
        den_mid_q <= wb;
      end
      if (we_dlow) begin
        den_low_q <= wb;
      end
      if (we_mod) begin
        mod_ctrl_q <= wb & `SFDC_MASK_NIB; // [R10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field assembly

  sfdc_field_if fields ();

  // both 22-bit fields share one packing: six top bits, then two full bytes
  function automatic logic [21:0] join22(input logic [7:0] top, input logic [7:0] mid, input logic [7:0] low);
    return {top[5:0], mid, low};
  endfunction

  assign fields.ndiv = {ndiv_hi_q[3:0], ndiv_lo_q}; // [R3] [R4]
  assign fields.numer = join22(num_top_q, num_mid_q, num_low_q); // [R5]
  assign fields.denom = join22(den_top_q, den_mid_q, den_low_q); // [R6]
  assign fields.order = mod_ctrl_q[1:0];
  assign fields.pump = pump_dbl_q[3:0];

  sfdc_ratio u_ratio (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .f(fields)
  );

  assign REF_DOUBLER_ENABLE = pump_dbl_q[`SFDC_DBL_BIT]; // [R1]
  assign PUMP_CURRENT_SELECT = pump_dbl_q[3:0]; // [R2]
  assign PUMP_CURRENT_TENTHS_MA = fields.pump_tenths;
  assign INTEGER_FEEDBACK_DIVIDER = fields.ndiv;
  assign FRACTION_NUMERATOR = fields.numer;
  assign FRACTION_DENOMINATOR = fields.denom;
  assign DITHER_SELECT = sfdc_dither_type'(mod_ctrl_q[3:2]); // [R7]
  assign MODULATOR_ORDER = sfdc_order_type'(mod_ctrl_q[1:0]); // [R8]
  assign RATIO_INTEGER = fields.ratio_int;
  assign RATIO_NUMERATOR = fields.ratio_num;
  assign RATIO_DENOMINATOR = fields.ratio_den;
  assign FRACTION_ACTIVE = fields.frac_active;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // wr_taken and rd_taken see a transfer at the edge that answers it, one edge after the register took it
  sequence wr_taken(logic [6:0] i);
    AVS_WRITE && AVS_BYTEENABLE[0] && !AVS_WAITREQUEST && hit(AVS_ADDRESS, i);
  endsequence

  sequence rd_taken(logic [6:0] i);
    AVS_READ && !AVS_WAITREQUEST && hit(AVS_ADDRESS, i);
  endsequence

  dbl_reset_a: assert property (@(posedge REF_CLK) // [R1]
    $rose(RST_N) |-> REF_DOUBLER_ENABLE && PUMP_CURRENT_SELECT == 4'h8)
    else $error("doubler or pump reset wrong");
  dbl_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R1]
    (req && we_pump) |=> ##1 (REF_DOUBLER_ENABLE == $past(AVS_WRITEDATA[4], 2)))
    else $error("doubler not written");
  ndiv_reset_a: assert property (@(posedge REF_CLK) // [R4]
    $rose(RST_N) |-> INTEGER_FEEDBACK_DIVIDER == 12'h066)
    else $error("divider reset wrong");
  numer_asm_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R5]
    wr_taken(`SFDC_IDX_NUM_TOP) |=> FRACTION_NUMERATOR[21:16] == $past(AVS_WRITEDATA[5:0]))
    else $error("numerator packing");
  denom_asm_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R6]
    wr_taken(`SFDC_IDX_DEN_MID) |=> FRACTION_DENOMINATOR[15:8] == $past(AVS_WRITEDATA[7:0]))
    else $error("denominator packing");
  mod_reset_a: assert property (@(posedge REF_CLK) // [R7]
    $rose(RST_N) |-> DITHER_SELECT == SFDC_DITHER_OFF)
    else $error("dither reset wrong");
  order_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R8]
    wr_taken(`SFDC_IDX_MOD_CTRL) |=> MODULATOR_ORDER == $past(AVS_WRITEDATA[1:0]))
    else $error("order not written");
  rsv_zero_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R10]
    pump_dbl_q[7:6] == 2'h0 && mod_ctrl_q[7:4] == 4'h0 && ndiv_hi_q[7:4] == 4'h0 &&
    num_top_q[7:6] == 2'h0 && den_top_q[7:6] == 2'h0)
    else $error("reserved bits set");
  frac_gate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R9]
    (MODULATOR_ORDER != SFDC_ORDER_INT) |=> FRACTION_ACTIVE)
    else $error("fraction not activated");
  pump_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R2]
    wr_taken(`SFDC_IDX_PUMP_DBL) |=> PUMP_CURRENT_SELECT == $past(AVS_WRITEDATA[3:0]))
    else $error("pump code not written");
  spare_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R10]
    wr_taken(`SFDC_IDX_PUMP_DBL) |=> pump_dbl_q[`SFDC_RSV5_BIT] == $past(AVS_WRITEDATA[5]))
    else $error("spare bit not stored");
  nhi_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R3]
    wr_taken(`SFDC_IDX_NDIV_HI) |=> INTEGER_FEEDBACK_DIVIDER[11:8] == $past(AVS_WRITEDATA[3:0]))
    else $error("divider high nibble not written");
  nlo_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R4]
    wr_taken(`SFDC_IDX_NDIV_LO) |=> INTEGER_FEEDBACK_DIVIDER[7:0] == $past(AVS_WRITEDATA[7:0]))
    else $error("divider low byte not written");
  ratio_int_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R3]
    (INTEGER_FEEDBACK_DIVIDER != 12'h000) |=> RATIO_INTEGER == $past(INTEGER_FEEDBACK_DIVIDER))
    else $error("divider ratio not direct");
  nmid_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R5]
    wr_taken(`SFDC_IDX_NUM_MID) |=> FRACTION_NUMERATOR[15:8] == $past(AVS_WRITEDATA[7:0]))
    else $error("numerator middle byte not written");
  dtop_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R6]
    wr_taken(`SFDC_IDX_DEN_TOP) |=> FRACTION_DENOMINATOR[21:16] == $past(AVS_WRITEDATA[5:0]))
    else $error("denominator top bits not written");
  dlow_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R6]
    wr_taken(`SFDC_IDX_DEN_LOW) |=> FRACTION_DENOMINATOR[7:0] == $past(AVS_WRITEDATA[7:0]))
    else $error("denominator low byte not written");
  dither_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R7]
    wr_taken(`SFDC_IDX_MOD_CTRL) |=> DITHER_SELECT == $past(AVS_WRITEDATA[3:2]))
    else $error("dither not written");
  ratio_den_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R9]
    (MODULATOR_ORDER != SFDC_ORDER_INT) |=> RATIO_DENOMINATOR == $past(FRACTION_DENOMINATOR))
    else $error("denominator not passed in fractional mode");
  rsv_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R10]
    rd_taken(`SFDC_IDX_PUMP_DBL) |-> AVS_READDATA[31:6] == 26'h0)
    else $error("reserved pump bits read nonzero");
  bad_addr_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R10]
    (req && !in_range) |=> AVS_RESPONSE == 2'h2 && AVS_READDATA == 32'h0)
    else $error("unmapped access not refused");
endmodule

// file: core/sfdc_field_if.sv
// assembled synthesizer fields carried from the register bank to the field decoder
`timescale 1ns/1ps
interface sfdc_field_if;
  logic [11:0] ndiv;
  logic [21:0] numer;
  logic [21:0] denom;
  logic [1:0] order;
  logic [3:0] pump;
  logic [11:0] ratio_int;
  logic [21:0] ratio_num;
  logic [21:0] ratio_den;
  logic frac_active;
  logic [6:0] pump_tenths;
  modport bank (output ndiv, numer, denom, order, pump, input ratio_int, ratio_num, ratio_den, frac_active,
    pump_tenths);
  modport decode (input ndiv, numer, denom, order, pump, output ratio_int, ratio_num, ratio_den, frac_active,
    pump_tenths);
endinterface

// file: core/sfdc_pkg.sv
// types shared by the synthesizer config bank
package sfdc_pkg;
  typedef enum logic [1:0] {
    SFDC_DITHER_WEAK = 2'h0,
    SFDC_DITHER_MEDIUM = 2'h1,
    SFDC_DITHER_STRONG = 2'h2,
    SFDC_DITHER_OFF = 2'h3
  } sfdc_dither_type;
  typedef enum logic [1:0] {
    SFDC_ORDER_INT = 2'h0,
    SFDC_ORDER_ONE = 2'h1,
    SFDC_ORDER_TWO = 2'h2,
    SFDC_ORDER_THREE = 2'h3
  } sfdc_order_type;
  typedef enum logic [1:0] {
    SFDC_ST_IDLE = 2'b01,
    SFDC_ST_ANSWER = 2'b10
  } sfdc_state_type;
endpackage

// file: core/sfdc_ratio.sv
// decodes divider ratio and pump current from the assembled fields
`timescale 1ns/1ps
module sfdc_ratio (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fields
  sfdc_field_if.decode f
);
  import sfdc_pkg::*;

  // pump current in tenths of a milliampere
  function automatic logic [6:0] pump_tenths_of(input logic [3:0] code);
    logic [6:0] t;
    t = 7'h0;
    if (code[3]) begin
      t = 7'h40;
    end else begin
      t = (code[0] ? 7'h04 : 7'h00) + (code[1] ? 7'h08 : 7'h00) + (code[2] ? 7'h10 : 7'h00); // [R2]
    end
    return t;
  endfunction

  wire logic frac_on;
  wire logic [11:0] int_eff;
  assign frac_on = (f.order != SFDC_ORDER_INT); // [R9]
  // a zero divider still divides by one
  assign int_eff = (f.ndiv == 12'h000) ? 12'h001 : f.ndiv; // [R3]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f.ratio_int <= 12'h001;
      f.ratio_num <= 22'h0;
      f.ratio_den <= 22'h0;
      f.frac_active <= 1'b0;
      f.pump_tenths <= 7'h40;
    end else begin
      f.ratio_int <= int_eff;
      f.ratio_num <= frac_on ? f.numer : 22'h0; // [R9]
      f.ratio_den <= frac_on ? f.denom : 22'h0; // [R9]
      f.frac_active <= frac_on;
      f.pump_tenths <= pump_tenths_of(f.pump);
    end
  end

  ratio_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    (f.ndiv == 12'h000) |=> (f.ratio_int == 12'h001))
    else $error("zero divider not mapped to one");
  int_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    (f.order == SFDC_ORDER_INT) |=> (f.ratio_num == 22'h0 && !f.frac_active))
    else $error("fraction used in integer mode");
  pump_top_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    (f.pump == 4'h8) |=> (f.pump_tenths == 7'h40))
    else $error("pump code 8 not 6.4 mA");
endmodule

// file: core/sfdc_regs.svh
// register offsets, field positions, reset values for the synthesizer config bank
`ifndef SFDC_REGS_SVH
`define SFDC_REGS_SVH
`define SFDC_IDX_PUMP_DBL 7'h39
`define SFDC_IDX_NDIV_HI 7'h3a
`define SFDC_IDX_NDIV_LO 7'h3b
`define SFDC_IDX_NUM_TOP 7'h3c
`define SFDC_IDX_NUM_MID 7'h3d
`define SFDC_IDX_NUM_LOW 7'h3e
`define SFDC_IDX_DEN_TOP 7'h3f
`define SFDC_IDX_DEN_MID 7'h40
`define SFDC_IDX_DEN_LOW 7'h41
`define SFDC_IDX_MOD_CTRL 7'h42
`define SFDC_DBL_BIT 4
`define SFDC_RSV5_BIT 5
`define SFDC_CP_RST 4'h8
`define SFDC_NDIV_LO_RST 8'h66
`define SFDC_NDIV_HI_RST 4'h0
`define SFDC_DITHER_RST 2'h3
`define SFDC_ORDER_RST 2'h0
`define SFDC_DBL_RST 1'h1
`define SFDC_MASK_PUMP 8'h3f
`define SFDC_MASK_NIB 8'h0f
`define SFDC_MASK_TOP6 8'h3f
`define SFDC_MASK_FULL 8'hff
`endif

// file: tb/testbench.sv
// self-checking bench for the synthesizer config register bank
`timescale 1ns/1ps
`include "sfdc_regs.svh"
module testbench;
  import sfdc_pkg::*;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [8:0] AVS_ADDRESS = 9'h000;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic [1:0] AVS_RESPONSE;
  logic AVS_WAITREQUEST;
  logic REF_DOUBLER_ENABLE;
  logic [3:0] PUMP_CURRENT_SELECT;
  logic [6:0] PUMP_CURRENT_TENTHS_MA;
  logic [11:0] INTEGER_FEEDBACK_DIVIDER;
  logic [21:0] FRACTION_NUMERATOR;
  logic [21:0] FRACTION_DENOMINATOR;
  sfdc_dither_type DITHER_SELECT;
  sfdc_order_type MODULATOR_ORDER;
  logic [11:0] RATIO_INTEGER;
  logic [21:0] RATIO_NUMERATOR;
  logic [21:0] RATIO_DENOMINATOR;
  logic FRACTION_ACTIVE;
  int err_count = 0;
  int checked = 0;
  int seed = 32'h4cb4adac;
  logic [7:0] sh [10];
  logic [7:0] rst_val [10] = '{8'h18, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c};
  logic [7:0] mask [10] = '{8'h3f, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h0f};
  logic [31:0] exp_data [$];
  logic [1:0] exp_resp [$];

  sfdc_bank i_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .REF_DOUBLER_ENABLE(REF_DOUBLER_ENABLE), .PUMP_CURRENT_SELECT(PUMP_CURRENT_SELECT),
    .PUMP_CURRENT_TENTHS_MA(PUMP_CURRENT_TENTHS_MA), .INTEGER_FEEDBACK_DIVIDER(INTEGER_FEEDBACK_DIVIDER),
    .FRACTION_NUMERATOR(FRACTION_NUMERATOR), .FRACTION_DENOMINATOR(FRACTION_DENOMINATOR),
    .DITHER_SELECT(DITHER_SELECT), .MODULATOR_ORDER(MODULATOR_ORDER), .RATIO_INTEGER(RATIO_INTEGER),
    .RATIO_NUMERATOR(RATIO_NUMERATOR), .RATIO_DENOMINATOR(RATIO_DENOMINATOR),
    .FRACTION_ACTIVE(FRACTION_ACTIVE));

  always #25 REF_CLK = ~REF_CLK;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cf(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_read(input logic [31:0] d, input logic [1:0] r);
    if (exp_data.size() == 0) begin
      err_count++;
      $display("BAD read answer expected none seen %h", d);
    end else begin
      cf("readdata", exp_data.pop_front(), d);
      cf("response", exp_resp.pop_front(), r);
    end
  endtask

  // the monitor samples at the edge where waitrequest is seen low, before the release lands
  always @(posedge REF_CLK) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
      chk_read(AVS_READDATA, AVS_RESPONSE);
    end
  end

  task automatic bus(input logic wr, input logic [8:0] addr, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = $random(seed);
    @(posedge REF_CLK);
    AVS_ADDRESS <= addr;
    // upper data lanes carry noise, they must be ignored
    AVS_WRITEDATA <= {r[31:8], d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    @(posedge REF_CLK);
    // no answer time is assumed; only the watchdog ends a hung wait
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(posedge REF_CLK);
    end
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  task automatic wreg(input int i, input logic [7:0] d, input logic [3:0] be);
    bus(1'b1, {`SFDC_IDX_PUMP_DBL + 7'(i), 2'b00}, d, be);
    if (be[0]) begin
      sh[i] = d & mask[i];
    end
  endtask

  task automatic rreg(input int i);
    exp_data.push_back({24'h0, sh[i]});
    exp_resp.push_back(2'b00);
    bus(1'b0, {`SFDC_IDX_PUMP_DBL + 7'(i), 2'b00}, 8'h00, 4'hf);
  endtask

  task automatic bad_read(input logic [8:0] addr);
    exp_data.push_back(32'h0);
    exp_resp.push_back(2'b10);
    bus(1'b0, addr, 8'h00, 4'hf);
  endtask

  task automatic chk_fields;
    logic [11:0] nd;
    logic [21:0] nm;
    logic [21:0] dn;
    logic [3:0] pc;
    logic fa;
    nd = {sh[1][3:0], sh[2]};
    nm = {sh[3][5:0], sh[4], sh[5]};
    dn = {sh[6][5:0], sh[7], sh[8]};
    pc = sh[0][3:0];
    fa = sh[9][1:0] != 2'b00;
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    cf("doubler", sh[0][4], REF_DOUBLER_ENABLE);
    cf("pump", pc, PUMP_CURRENT_SELECT);
    cf("pump_tenths", pc[3] ? 7'h40 : {2'b00, pc[2:0], 2'b00}, PUMP_CURRENT_TENTHS_MA);
    cf("divider", nd, INTEGER_FEEDBACK_DIVIDER);
    cf("ratio_int", (nd == 12'h000) ? 12'h001 : nd, RATIO_INTEGER);
    cf("numerator", nm, FRACTION_NUMERATOR);
    cf("denominator", dn, FRACTION_DENOMINATOR);
    cf("dither", sh[9][3:2], DITHER_SELECT);
    cf("order", sh[9][1:0], MODULATOR_ORDER);
    cf("frac_active", fa, FRACTION_ACTIVE);
    cf("ratio_num", fa ? nm : 22'h0, RATIO_NUMERATOR);
    cf("ratio_den", fa ? dn : 22'h0, RATIO_DENOMINATOR);
  endtask

  task automatic reset_check;
    for (int i = 0; i < 10; i++) begin
      sh[i] = rst_val[i];
    end
    for (int i = 0; i < 10; i++) begin
      rreg(i);
    end
    chk_fields();
  endtask

  task automatic finish_test;
    $display("counts: checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    repeat (12) @(posedge REF_CLK);
    RST_N <= 1'b1;
    reset_check();
    $display("test reset_values done");
    repeat (3) begin
      for (int i = 0; i < 10; i++) begin
        r = $random(seed);
        wreg(i, r[7:0], 4'h1);
      end
      for (int i = 0; i < 10; i++) begin
        rreg(i);
      end
      chk_fields();
    end
    $display("test random_fill done");
    // nibble repeated so doubler and the stored spare bit move along with the code
    for (int c = 0; c < 16; c++) begin
      wreg(0, 8'(c * 17), 4'h1);
      rreg(0);
      chk_fields();
    end
    $display("test pump_codes done");
    wreg(1, 8'h00, 4'h1);
    wreg(2, 8'h00, 4'h1);
    chk_fields();
    wreg(2, 8'h01, 4'h1);
    chk_fields();
    wreg(1, 8'hff, 4'h1);
    wreg(2, 8'hff, 4'h1);
    chk_fields();
    $display("test divider_limits done");
    for (int m = 0; m < 16; m++) begin
      r = $random(seed);
      wreg(9, {r[7:4], 4'(m)}, 4'h1);
      rreg(9);
      chk_fields();
    end
    $display("test modulator_modes done");
    wreg(2, 8'h5a, 4'he);
    bus(1'b1, {7'h43, 2'b00}, 8'ha5, 4'h1);
    bus(1'b1, {`SFDC_IDX_NDIV_LO, 2'b10}, 8'ha5, 4'h1);
    bad_read({7'h43, 2'b00});
    bad_read({7'h10, 2'b00});
    bad_read({`SFDC_IDX_NDIV_LO, 2'b01});
    rreg(2);
    chk_fields();
    $display("test refused_access done");
    @(posedge REF_CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    reset_check();
    $display("test second_reset done");
    repeat (4) @(posedge REF_CLK);
    if (exp_data.size() != 0) begin
      err_count++;
      $display("BAD pending_reads expected 0 seen %0d", exp_data.size());
    end
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge REF_CLK);
    err_count++;
    $display("test watchdog expired");
    finish_test();
  end
endmodule
